//--- servo_speed_consts.svh
// Notes on behaviour
// - Accel ramp time is the time to rise from zero to 1000 RPM.
// - Decel ramp time is the time to fall from 1000 RPM to zero.
// - Common limit, 0 to 6000 RPM, default 6000, caps both directions.
// - Forward limit, 0 to 6000 RPM, default 6000, caps positive reference.
// - Reverse limit, 0 to 6000 RPM, default 6000, caps negative magnitude.
// - Each direction uses the smallest of motor maximum, common and own limit.
// - Feedforward select: 0 off, 1 internal (default); never in torque control.
// - Feedforward source: position controller output, or limited and ramped speed reference.
// - Speed control, clamp input on, magnitude within threshold: enter zero clamp.
// - While clamped, ignore reference and hold within one pulse of entry.
// - Magnitude above the clamp threshold leaves zero clamp.
// - Clamp input off means zero clamp never engages.
// - Turning flag on while filtered magnitude is at or above rotation threshold.
// - Turning flag ignores running state and control mode.
// - Match flag on while filtered speed minus reference is within threshold.
// - Match flag off when not running or not in speed control.
// - Reached flag on while filtered magnitude exceeds reached threshold.
// - Reached flag ignores running state and control mode.
// - Zero flag on while filtered magnitude is below zero threshold.
// - Zero flag ignores running state and control mode.
// - All status compares use speed filtered with a settable time constant.
`ifndef SERVO_SPEED_CONSTS_SVH
`define SERVO_SPEED_CONSTS_SVH
`define SPD_W              16
`define POS_W              32
`define FILT_FRAC          8
`define ACC_W              40
`define RAMP_SPAN_RPM      16'h03e8
`define LIMIT_DEFAULT_RPM  16'h1770
`define CLAMP_THR_DEFAULT  16'h000a
`define ROT_THR_DEFAULT    16'h0014
`define MATCH_THR_DEFAULT  16'h000a
`define REACH_THR_DEFAULT  16'h03e8
`define ZERO_THR_DEFAULT   16'h000a
`define FF_SEL_DEFAULT     1'b1
`define CLK_PERIOD_NS      4
`define RAMP_UNIT_NS       1000000
`define CYC_PER_MS         (`RAMP_UNIT_NS / `CLK_PERIOD_NS)
`endif

//--- servo_speed_pkg.sv
package servo_speed_pkg;
   typedef enum logic [1:0] {
      MODE_POSITION = 2'b00,
      MODE_SPEED    = 2'b01,
      MODE_TORQUE   = 2'b11
   } ctrl_mode_e;

   typedef struct packed {
      logic signed [15:0] ramp_ref;
      logic [39:0]        ramp_acc;
      logic               clamp;
      logic signed [31:0] entry_pos;
      logic signed [23:0] filt;
      logic signed [15:0] speed_cmd;
      logic signed [15:0] ff;
      logic               turning;
      logic               match;
      logic               reached;
      logic               zero;
   } state_s;
endpackage

//--- speed_compare.sv
`timescale 1ns/1ns
`default_nettype none
module speed_compare #(
   parameter int W = 16
) (
   input  wire logic [W-1:0] value_in,
   input  wire logic [W-1:0] threshold_in,
   output logic              at_or_above_out,
   output logic              above_out
);
   // Unsigned magnitudes only; callers fold the sign first
   assign at_or_above_out = (value_in >= threshold_in);
   assign above_out       = (value_in > threshold_in);
endmodule
`default_nettype wire

//--- servo_speed_limit_and_status.sv
`timescale 1ns/1ns
`default_nettype none
`include "servo_speed_consts.svh"
module servo_speed_limit_and_status #(
   parameter int CYC_PER_MS = `CYC_PER_MS,
   parameter int HOLD_SPEED = 10
) (
   input  wire logic                      clk_in,
   input  wire logic                      rstn_in,
   input  wire logic signed [15:0]        speed_ref_in,
   input  wire logic [15:0]               accel_ramp_time_in,
   input  wire logic [15:0]               decel_ramp_time_in,
   input  wire logic [15:0]               common_speed_limit_in,
   input  wire logic [15:0]               forward_speed_limit_in,
   input  wire logic [15:0]               reverse_speed_limit_in,
   input  wire logic [15:0]               motor_max_speed_in,
   input  wire logic                      feedforward_select_in,
   input  wire logic [1:0]                ctrl_mode_in,
   input  wire logic                      running_in,
   input  wire logic signed [15:0]        pos_ctrl_out_in,
   input  wire logic                      zero_hold_request_in,
   input  wire logic [15:0]               clamp_speed_threshold_in,
   input  wire logic signed [31:0]        motor_pos_in,
   input  wire logic signed [15:0]        motor_speed_in,
   input  wire logic [3:0]                speed_status_filter_tc_in,
   input  wire logic [15:0]               rotation_threshold_in,
   input  wire logic [15:0]               match_threshold_in,
   input  wire logic [15:0]               reached_threshold_in,
   input  wire logic [15:0]               zero_speed_threshold_in,
   output logic signed [15:0]             speed_ref_ramped_out,
   output logic signed [15:0]             speed_cmd_out,
   output logic signed [15:0]             feedforward_out,
   output logic                           clamp_active_out,
   output logic                           motor_turning_flag_out,
   output logic                           speed_match_flag_out,
   output logic                           speed_reached_flag_out,
   output logic                           zero_speed_flag_out
);

   servo_speed_pkg::state_s q;
   servo_speed_pkg::state_s d;

   logic [15:0]        fwd_lim;
   logic [15:0]        rev_lim;
   logic signed [15:0] target;
   logic [15:0]        filt_mag;
   logic [15:0]        diff_mag;
   logic               rot_ge;
   logic               reach_gt;
   logic               zero_ge;
   logic               match_gt;

   ////////////////////////////////////////////////////////////////////////////
   // Limits and sign-keeping clamp

   function automatic logic [15:0] min3(input logic [15:0] a,
                                        input logic [15:0] b,
                                        input logic [15:0] c);
      logic [15:0] m;
      m = (a < b) ? a : b;
      return (m < c) ? m : c;
   endfunction

   function automatic logic [15:0] mag16(input logic signed [15:0] v);
      return v[15] ? 16'(-v) : 16'(v);
   endfunction

   always_comb begin
      fwd_lim = min3(motor_max_speed_in, common_speed_limit_in,
                     forward_speed_limit_in);
      rev_lim = min3(motor_max_speed_in, common_speed_limit_in,
                     reverse_speed_limit_in);
      if (!speed_ref_in[15] && (16'(speed_ref_in) > fwd_lim)) begin
         target = signed'(fwd_lim);
      end else if (speed_ref_in[15] && (mag16(speed_ref_in) > rev_lim)) begin
         target = signed'(16'(-rev_lim));
      end else begin
         target = speed_ref_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status compares on filtered speed

   assign filt_mag = mag16(q.filt[23:8]);
   assign diff_mag = mag16(16'(q.filt[23:8] - q.ramp_ref));

   speed_compare #(.W(16)) u_rot (
      .value_in        (filt_mag),
      .threshold_in    (rotation_threshold_in),
      .at_or_above_out (rot_ge),
      .above_out       ()
   );

   speed_compare #(.W(16)) u_reach (
      .value_in        (filt_mag),
      .threshold_in    (reached_threshold_in),
      .at_or_above_out (),
      .above_out       (reach_gt)
   );

   speed_compare #(.W(16)) u_zero (
      .value_in        (filt_mag),
      .threshold_in    (zero_speed_threshold_in),
      .at_or_above_out (zero_ge),
      .above_out       ()
   );

   speed_compare #(.W(16)) u_match (
      .value_in        (diff_mag),
      .threshold_in    (match_threshold_in),
      .at_or_above_out (),
      .above_out       (match_gt)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   logic               moving_up;
   logic               away_from_zero;
   logic [15:0]        ramp_ms;
   logic [39:0]        ramp_lim;
   logic [39:0]        acc_next;
   logic signed [31:0] hold_err;
   logic signed [24:0] filt_diff;

   always_comb begin
      d = q;
      // Magnitude growing uses accel time, shrinking uses decel; a zero crossing switches to accel at zero
      moving_up      = (target > q.ramp_ref);
      away_from_zero = moving_up ? !q.ramp_ref[15] : (q.ramp_ref[15] || q.ramp_ref == 16'sh0);
      ramp_ms        = away_from_zero ? accel_ramp_time_in : decel_ramp_time_in;
      ramp_lim       = 40'(ramp_ms) * 40'(CYC_PER_MS);
      acc_next       = q.ramp_acc + 40'(`RAMP_SPAN_RPM);
      if (target == q.ramp_ref) begin
         d.ramp_acc = 40'h0;
      end else if (ramp_ms == 16'h0) begin
         d.ramp_ref = target;
         d.ramp_acc = 40'h0;
      end else if (acc_next >= ramp_lim) begin
         // One RPM per (time x rate) / 1000 cycles; capped at one RPM a cycle
         d.ramp_ref = moving_up ? 16'(q.ramp_ref + 16'sh1) : 16'(q.ramp_ref - 16'sh1);
         d.ramp_acc = (ramp_lim <= 40'(`RAMP_SPAN_RPM)) ? 40'h0 : acc_next - ramp_lim;
      end else begin
         d.ramp_acc = acc_next;
      end

      // Zero clamp, judged on the ramped reference
      if (!zero_hold_request_in || ctrl_mode_in != servo_speed_pkg::MODE_SPEED) begin
         d.clamp = 1'b0;
      end else if (mag16(q.ramp_ref) <= clamp_speed_threshold_in) begin
         d.clamp = 1'b1;
         if (!q.clamp) begin
            d.entry_pos = motor_pos_in;
         end
      end else begin
         d.clamp = 1'b0;
      end

      // Bang-bang hold; dead band of one pulse either side of entry
      hold_err = d.entry_pos - motor_pos_in;
      if (!d.clamp) begin
         d.speed_cmd = q.ramp_ref;
      end else if (hold_err > 32'sh1) begin
         d.speed_cmd = 16'(HOLD_SPEED);
      end else if (hold_err < -32'sh1) begin
         d.speed_cmd = 16'(-HOLD_SPEED);
      end else begin
         d.speed_cmd = 16'sh0;
      end

      if (!feedforward_select_in || ctrl_mode_in == servo_speed_pkg::MODE_TORQUE) begin
         d.ff = 16'sh0;
      end else if (ctrl_mode_in == servo_speed_pkg::MODE_POSITION) begin
         d.ff = pos_ctrl_out_in;
      end else begin
         d.ff = q.ramp_ref;
      end

      // First order filter, time constant is 2^tc cycles
      // Sign kept on the scaled speed so a reverse speed filters downward
      filt_diff = 25'(signed'({motor_speed_in, 8'h0})) - 25'(q.filt);
      d.filt    = 24'(q.filt + 24'(filt_diff >>> speed_status_filter_tc_in));

      d.turning = rot_ge;
      d.reached = reach_gt;
      d.zero    = !zero_ge;
      d.match   = running_in && ctrl_mode_in == servo_speed_pkg::MODE_SPEED
                  && !match_gt;
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign speed_ref_ramped_out   = q.ramp_ref;
   assign speed_cmd_out          = q.speed_cmd;
   assign feedforward_out        = q.ff;
   assign clamp_active_out       = q.clamp;
   assign motor_turning_flag_out = q.turning;
   assign speed_match_flag_out   = q.match;
   assign speed_reached_flag_out = q.reached;
   assign zero_speed_flag_out    = q.zero;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);

   chk_fwd_clamp: assert property (!target[15] |-> 16'(target) <= fwd_lim)
      else $error("positive target above forward limit");
   chk_rev_clamp: assert property (target[15] |-> mag16(target) <= rev_lim)
      else $error("negative target above reverse limit");
   chk_common_cap: assert property (mag16(target) <= common_speed_limit_in)
      else $error("target above common limit");
   chk_sign_kept: assert property (speed_ref_in[15] == target[15] || target == 16'sh0)
      else $error("clamp changed sign");
   chk_ramp_instant: assert property (accel_ramp_time_in == 16'h0 && decel_ramp_time_in == 16'h0
      |=> speed_ref_ramped_out == $past(target))
      else $error("zero ramp time did not jump");
   chk_clamp_off: assert property (!zero_hold_request_in |=> !clamp_active_out)
      else $error("clamp engaged without request");
   chk_hold_dir: assert property (clamp_active_out && q.entry_pos - motor_pos_in > 32'sh1
      && $stable(motor_pos_in) && zero_hold_request_in |=> speed_cmd_out > 16'sh0)
      else $error("hold did not push toward entry");
   chk_match_gate: assert property (!running_in |=> !speed_match_flag_out)
      else $error("match flag while not running");
   chk_turning_rel: assert property (##1 motor_turning_flag_out
      == ($past(filt_mag) >= $past(rotation_threshold_in)))
      else $error("turning flag wrong");
   chk_ff_off: assert property (!feedforward_select_in |=> feedforward_out == 16'sh0)
      else $error("feedforward not off");

   cov_clamp_entry: cover property (!clamp_active_out ##1 clamp_active_out);
   cov_ramp_step: cover property (accel_ramp_time_in != 16'h0
      && $changed(speed_ref_ramped_out));
   cov_all_flags: cover property (motor_turning_flag_out && speed_match_flag_out
      && speed_reached_flag_out);
endmodule
`default_nettype wire

//--- motor_model.sv
`timescale 1ns/1ns
`default_nettype none
module motor_model (
   input  wire logic               clk_in,
   input  wire logic               rstn_in,
   input  wire logic signed [15:0] speed_cmd_in,
   input  wire logic               force_in,
   input  wire logic signed [15:0] force_speed_in,
   input  wire logic signed [31:0] push_in,
   output logic signed [15:0]      speed_out,
   output logic signed [31:0]      pos_out
);
   ////////////////////////////////////////////////////////////////////////////
   // Shaft steps one pulse a cycle while turning: slow, but enough to close the hold loop
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         speed_out <= 16'sh0000;
         pos_out   <= 32'sh0000_0064;
      end else begin
         speed_out <= force_in ? force_speed_in : speed_cmd_in;
         pos_out   <= pos_out + push_in + ((speed_out > 0) ? 32'sh1 : 32'sh0)
                      - ((speed_out < 0) ? 32'sh1 : 32'sh0);
      end
   end
endmodule
`default_nettype wire

//--- servo_speed_limit_and_status_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module servo_speed_limit_and_status_tb_top;
   typedef struct packed {
      logic signed [15:0] spd;
      logic [3:0]         exp;
   } row_s;
   logic               clk_in, rstn_in, ff_sel, running, hold_req, force_en;
   logic signed [15:0] sref, pctl, fspd, ramped, cmd, ff, mspd;
   logic [15:0]        acc_t, dec_t, com_l, fwd_l, rev_l, mmax;
   logic [15:0]        clamp_t, rot_t, mat_t, rch_t, zer_t;
   logic [1:0]         mode;
   logic [3:0]         tc;
   logic signed [31:0] mpos, push, entry;
   logic               clamp_o, turn_o, match_o, reach_o, zero_o;
   int                 failures, checks_done, cycles, k;
   row_s               rows [10];
   ////////////////////////////////////////////////////////////////////////////
   servo_speed_limit_and_status #(.CYC_PER_MS(4), .HOLD_SPEED(10)) servo_speed_limit_and_status_inst (
      .clk_in(clk_in), .rstn_in(rstn_in), .speed_ref_in(sref),
      .accel_ramp_time_in(acc_t), .decel_ramp_time_in(dec_t),
      .common_speed_limit_in(com_l), .forward_speed_limit_in(fwd_l),
      .reverse_speed_limit_in(rev_l), .motor_max_speed_in(mmax),
      .feedforward_select_in(ff_sel), .ctrl_mode_in(mode), .running_in(running),
      .pos_ctrl_out_in(pctl), .zero_hold_request_in(hold_req),
      .clamp_speed_threshold_in(clamp_t), .motor_pos_in(mpos), .motor_speed_in(mspd),
      .speed_status_filter_tc_in(tc), .rotation_threshold_in(rot_t),
      .match_threshold_in(mat_t), .reached_threshold_in(rch_t),
      .zero_speed_threshold_in(zer_t), .speed_ref_ramped_out(ramped), .speed_cmd_out(cmd),
      .feedforward_out(ff), .clamp_active_out(clamp_o), .motor_turning_flag_out(turn_o),
      .speed_match_flag_out(match_o), .speed_reached_flag_out(reach_o),
      .zero_speed_flag_out(zero_o));
   motor_model motor_model_inst (
      .clk_in(clk_in), .rstn_in(rstn_in), .speed_cmd_in(cmd), .force_in(force_en),
      .force_speed_in(fspd), .push_in(push), .speed_out(mspd), .pos_out(mpos));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   // Ceiling well above the roughly 600 cycles the tests need
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         final_report();
      end
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   task automatic lim(input logic signed [15:0] r, input logic [15:0] c, input logic [15:0] f,
                      input logic [15:0] v, input logic [15:0] m, input logic signed [15:0] e);
      sref  = r;
      com_l = c;
      fwd_l = f;
      rev_l = v;
      mmax  = m;
      cyc(3);
      chk(32'(ramped), 32'(e), "limited reference");
   endtask
   task automatic final_report();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {rstn_in, hold_req, push, pctl, fspd, sref, acc_t, dec_t, tc} = '0;
      {ff_sel, running, force_en} = 3'h7;
      mode = servo_speed_pkg::MODE_SPEED;
      {com_l, fwd_l, rev_l, mmax} = {4{16'h1770}};
      {clamp_t, rot_t, mat_t, rch_t, zer_t} = {16'h000a, 16'h0014, 16'h000a, 16'h03e8, 16'h000a};
      rows = '{'{16'sh0000, 4'h3}, '{16'sh0009, 4'h3}, '{16'sh000a, 4'h1}, '{16'sh000b, 4'h0},
               '{16'sh0013, 4'h0}, '{16'sh0014, 4'h8}, '{-16'sh0014, 4'h8},
               '{16'sh03e8, 4'h8}, '{16'sh03e9, 4'hc}, '{-16'sh03e9, 4'hc}};
      cyc(4);
      chk({29'h0, zero_o, clamp_o, turn_o}, 32'h0, "outputs in reset");
      cyc(1);
      rstn_in = 1'b1;
      cyc(3);
      chk({31'h0, zero_o}, 32'h1, "zero flag after reset");
      done("reset");
      // Flag table, unfiltered, reference zero
      for (k = 0; k < 10; k++) begin
         fspd = rows[k].spd;
         cyc(3);
         chk({28'h0, turn_o, reach_o, zero_o, match_o}, {28'h0, rows[k].exp}, "flags");
      end
      done("flag table");
      fspd = 16'sh0000;
      running = 1'b0;
      cyc(3);
      chk({30'h0, match_o, zero_o}, 32'h1, "stopped");
      running = 1'b1;
      mode = servo_speed_pkg::MODE_TORQUE;
      cyc(3);
      chk({30'h0, match_o, zero_o}, 32'h1, "torque mode");
      fspd = 16'sh05dc;
      cyc(3);
      chk({30'h0, turn_o, reach_o}, 32'h3, "torque mode turning");
      done("mode independence");
      fspd = 16'sh0000;
      cyc(3);
      tc = 4'h4;
      fspd = 16'sh0064;
      cyc(2);
      chk({31'h0, turn_o}, 32'h0, "filtered early");
      cyc(150);
      chk({31'h0, turn_o}, 32'h1, "filtered late");
      tc = 4'h0;
      force_en = 1'b0;
      done("filter");
      mode = servo_speed_pkg::MODE_SPEED;
      lim(16'sh1388, 16'h0bb8, 16'h07d0, 16'h1770, 16'h1770, 16'sh07d0);
      lim(16'sh1388, 16'h0708, 16'h07d0, 16'h1770, 16'h1770, 16'sh0708);
      lim(-16'sh1388, 16'h1770, 16'h1770, 16'h05dc, 16'h1770, -16'sh05dc);
      lim(-16'sh1388, 16'h04b0, 16'h1770, 16'h05dc, 16'h1770, -16'sh04b0);
      lim(16'sh1388, 16'h1770, 16'h1770, 16'h1770, 16'h0384, 16'sh0384);
      lim(-16'sh012c, 16'h1770, 16'h1770, 16'h05dc, 16'h1770, -16'sh012c);
      lim(16'sh01f4, 16'h1770, 16'h1770, 16'h1770, 16'h1770, 16'sh01f4);
      done("limits");
      chk(32'(ff), 32'sh1f4, "speed mode feedforward");
      mode = servo_speed_pkg::MODE_POSITION;
      pctl = 16'sh007b;
      cyc(3);
      chk(32'(ff), 32'sh7b, "position mode feedforward");
      ff_sel = 1'b0;
      cyc(3);
      chk(32'(ff), 32'sh0, "feedforward off");
      ff_sel = 1'b1;
      mode = servo_speed_pkg::MODE_TORQUE;
      cyc(3);
      chk(32'(ff), 32'sh0, "torque mode feedforward");
      mode = servo_speed_pkg::MODE_SPEED;
      done("feedforward");
      sref = 16'sh0000;
      cyc(3);
      {acc_t, dec_t} = {16'h03e8, 16'h07d0};
      // One step per four cycles up, per eight down, at four cycles a unit
      sref = 16'sh0014;
      cyc(42);
      chk({31'h0, ramped >= 9 && ramped <= 11}, 32'h1, "accel midway");
      cyc(50);
      chk(32'(ramped), 32'sh14, "accel end");
      sref = 16'sh0000;
      cyc(82);
      chk({31'h0, ramped >= 9 && ramped <= 11}, 32'h1, "decel midway");
      cyc(100);
      chk(32'(ramped), 32'sh0, "decel end");
      {acc_t, dec_t} = '0;
      done("ramps");
      cyc(30);
      hold_req = 1'b1;
      sref = 16'sh0005;
      cyc(3);
      chk({30'h0, clamp_o, cmd == 0}, 32'h3, "clamp entry");
      entry = mpos;
      push = 32'sh5;
      cyc(1);
      push = 32'sh0;
      for (k = 0; k < 10 && cmd != -16'sh000a; k++)
         cyc(1);
      chk(32'(cmd), -32'sh000a, "hold pulls back");
      cyc(40);
      chk({31'h0, mpos - entry <= 1 && entry - mpos <= 1}, 32'h1, "held position");
      sref = 16'sh000b;
      cyc(3);
      chk({31'h0, clamp_o}, 32'h0, "clamp exit");
      chk(32'(cmd), 32'sh000b, "reference followed");
      hold_req = 1'b0;
      sref = 16'sh0000;
      cyc(3);
      chk({31'h0, clamp_o}, 32'h0, "request low");
      done("zero clamp");
      final_report();
   end
endmodule
`default_nettype wire
